// ===== src/pqi_core.sv
`timescale 1ns/1ps
`include "pqi_regs.svh"
module pqi_core
  import pqi_pkg::*;
#(
  parameter int DEPTH = 8,
  parameter int NPKT  = 64
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [1:0]  reg_bank,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [1:0]  reg_be,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        rx_start,
  input  wire logic        rx_word_vld,
  input  wire logic [15:0] rx_word,
  input  wire logic        rx_page_need,
  input  wire logic        rx_overrun,
  input  wire logic        rx_end,
  input  wire logic        rx_crc_ok,
  input  wire logic [15:0] rx_status,
  input  wire logic [10:0] rx_bytes,
  output logic             mem_we,
  output logic      [5:0]  mem_pkt,
  output logic      [10:0] mem_addr,
  output logic      [15:0] mem_wdata,
  output logic             alloc_req,
  output logic             free_req,
  output logic      [5:0]  free_pkt,
  input  wire logic        alloc_ok,
  input  wire logic [5:0]  alloc_pkt,
  output logic             tx_go,
  output logic      [5:0]  tx_pkt,
  input  wire logic        tx_done,
  input  wire logic        tx_ok,
  output logic             irq
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH || NPKT != 64) begin : g_bad_param
    $error("pqi_core: bad parameters");
  end

  typedef logic [5:0] pqi_q_t [DEPTH];
  typedef struct packed {
    pqi_rx_st_t  rx_st;
    logic [5:0]  rx_pkt;
    logic [10:0] rx_addr;
    logic        rx_ok;
    logic [15:0] txctl;
    logic [1:0]  rxctl;
    logic [7:0]  pnum;
    logic [7:0]  mask;
    logic        tx_last_ok;
    logic        tx_busy;
    logic [AW:0] rxq_cnt;
    logic [AW:0] dq_cnt;
    logic [AW:0] tq_cnt;
    logic [AW-1:0] rxq_rp;
    logic [AW-1:0] dq_rp;
    logic [AW-1:0] tq_rp;
    logic        mem_we;
    logic [10:0] mem_addr;
    logic [15:0] mem_wdata;
    logic [5:0]  mem_pkt;
    logic        alloc_req;
    logic        free_req;
    logic [5:0]  free_pkt;
    logic        tx_go;
    logic [15:0] rdata;
  } pqi_state_t;

  pqi_state_t s_r;
  pqi_state_t s_nxt;
  pqi_q_t rxq_r;
  pqi_q_t dq_r;
  pqi_q_t tq_r;

  function automatic logic [AW-1:0] wr_ptr(input logic [AW-1:0] rp, input logic [AW:0] cnt);
    wr_ptr = rp + cnt[AW-1:0];
  endfunction

  function automatic logic hit(input logic [1:0] b, input logic [3:0] a,
                               input logic [1:0] wb, input logic [3:0] wa);
    hit = (b == wb) && (a == wa);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic rxq_empty;
  logic dq_empty;
  logic tq_empty;
  logic [7:0] flags;
  assign rxq_empty = (s_r.rxq_cnt == '0);
  assign dq_empty  = (s_r.dq_cnt == '0);
  assign tq_empty  = (s_r.tq_cnt == '0);
  always_comb begin
    flags = 8'h00;
    flags[`PQI_IRQ_RX]      = !rxq_empty;
    flags[`PQI_IRQ_TX]      = !dq_empty;
    flags[`PQI_IRQ_TX_QUEUE_DRAINED] = tq_empty;
  end

  logic wr_alloc;
  logic wr_ack;
  logic rx_push;
  logic rx_pop;
  logic dq_push;
  logic dq_pop;
  logic tq_push;
  logic tq_pop;
  logic tx_fin;
  logic [5:0] tx_fin_pkt;
  assign wr_alloc = reg_wr && hit(reg_bank, reg_addr, 2'h2, `PQI_OFS_ALLOC);
  assign wr_ack   = reg_wr && reg_be[0] && hit(reg_bank, reg_addr, 2'h2, `PQI_OFS_IRQ)
                    && reg_wdata[7:0] == `PQI_ACK_TX;
  assign rx_pop   = wr_alloc && reg_wdata == `PQI_CMD_RXPOP && !rxq_empty;
  assign dq_pop   = wr_ack && !dq_empty;
  assign tq_push  = wr_alloc && reg_wdata == `PQI_CMD_ENQUEUE
                    && s_r.tq_cnt != DEPTH[AW:0];
  assign tx_fin   = tx_done && s_r.tx_busy;
  assign tx_fin_pkt = tq_r[s_r.tq_rp];
  assign tq_pop   = tx_fin;
  // Successful frames skip the completion queue under auto release
  assign dq_push  = tx_fin && (!tx_ok || !s_r.txctl[`PQI_BIT_AUTOREL])
                    && s_r.dq_cnt != DEPTH[AW:0];
  assign rx_push  = s_r.rx_st == PQI_CNT && s_r.rx_ok && s_r.rxq_cnt != DEPTH[AW:0];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    s_nxt.mem_we = 1'b0;
    s_nxt.alloc_req = 1'b0;
    s_nxt.free_req = 1'b0;
    s_nxt.tx_go = 1'b0;
    case (s_r.rx_st)
      PQI_IDLE: begin
        if (rx_start && s_r.rxctl[`PQI_BIT_RECEIVE_ENABLE_BIT]) begin
          s_nxt.alloc_req = 1'b1;
          s_nxt.rx_addr = 11'h004;
          s_nxt.rx_st = PQI_RECV;
        end
      end
      PQI_RECV: begin
        if (alloc_ok) s_nxt.rx_pkt = alloc_pkt;
        if (rx_page_need) s_nxt.alloc_req = 1'b1;
        if (rx_overrun) begin
          s_nxt.free_req = 1'b1;
          s_nxt.free_pkt = s_r.rx_pkt;
          s_nxt.rx_st = PQI_IDLE;
        end else if (rx_end) begin
          s_nxt.rx_ok = rx_crc_ok;
          s_nxt.mem_we = 1'b1;
          s_nxt.mem_addr = 11'h000;
          s_nxt.mem_wdata = rx_status;
          s_nxt.mem_pkt = s_r.rx_pkt;
          s_nxt.rx_st = PQI_STAT;
        end else if (rx_word_vld) begin
          s_nxt.mem_we = 1'b1;
          s_nxt.mem_addr = s_r.rx_addr;
          s_nxt.mem_wdata = rx_word;
          s_nxt.mem_pkt = s_r.rx_pkt;
          s_nxt.rx_addr = 11'(s_r.rx_addr + 11'h002);
        end
      end
      PQI_STAT: begin
        s_nxt.mem_we = 1'b1;
        s_nxt.mem_addr = 11'h002;
        s_nxt.mem_wdata = {5'h00, rx_bytes};
        s_nxt.rx_st = PQI_CNT;
      end
      PQI_CNT: begin
        if (!s_r.rx_ok || !rx_push) begin
          s_nxt.free_req = 1'b1;
          s_nxt.free_pkt = s_r.rx_pkt;
        end
        s_nxt.rx_st = PQI_IDLE;
      end
      default: s_nxt.rx_st = PQI_IDLE;
    endcase
    // One release per cycle: a later source in this process overrides an earlier one
    if (rx_pop) begin
      s_nxt.free_req = 1'b1;
      s_nxt.free_pkt = rxq_r[s_r.rxq_rp];
      s_nxt.rxq_rp = s_r.rxq_rp + 1'b1;
    end
    s_nxt.rxq_cnt = s_r.rxq_cnt + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
    if (wr_alloc && reg_wdata == `PQI_CMD_RELEASE) begin
      s_nxt.free_req = 1'b1;
      s_nxt.free_pkt = s_r.pnum[5:0];
    end
    if (tx_fin && tx_ok && s_r.txctl[`PQI_BIT_AUTOREL]) begin
      s_nxt.free_req = 1'b1;
      s_nxt.free_pkt = tx_fin_pkt;
    end
    // Transmit launcher
    if (s_r.tx_busy) begin
      if (tx_fin) begin
        s_nxt.tx_busy = 1'b0;
        s_nxt.tx_last_ok = tx_ok;
        s_nxt.tq_rp = s_r.tq_rp + 1'b1;
        if (!tx_ok) s_nxt.txctl[`PQI_BIT_TRANSMIT_ENABLE_BIT] = 1'b0;
      end
    end else if (!tq_empty && s_r.txctl[`PQI_BIT_TRANSMIT_ENABLE_BIT]) begin
      s_nxt.tx_busy = 1'b1;
      s_nxt.tx_go = 1'b1;
    end
    s_nxt.tq_cnt = s_r.tq_cnt + (AW+1)'(tq_push) - (AW+1)'(tq_pop);
    s_nxt.dq_cnt = s_r.dq_cnt + (AW+1)'(dq_push) - (AW+1)'(dq_pop);
    if (dq_pop) s_nxt.dq_rp = s_r.dq_rp + 1'b1;
    // Register writes; the hardware clear of enable above loses to software set
    if (reg_wr && hit(reg_bank, reg_addr, 2'h0, `PQI_OFS_TXCTL)) begin
      if (reg_be[0]) s_nxt.txctl[7:0] = reg_wdata[7:0];
      if (reg_be[1]) s_nxt.txctl[15:8] = reg_wdata[15:8];
    end
    if (reg_wr && reg_be[0] && hit(reg_bank, reg_addr, 2'h0, `PQI_OFS_RXCTL))
      s_nxt.rxctl = reg_wdata[1:0];
    if (reg_wr && reg_be[0] && hit(reg_bank, reg_addr, 2'h2, `PQI_OFS_PNUM))
      s_nxt.pnum = reg_wdata[7:0];
    if (reg_wr && reg_be[1] && hit(reg_bank, reg_addr, 2'h2, `PQI_OFS_IRQ))
      s_nxt.mask = reg_wdata[15:8];
    // Read data
    s_nxt.rdata = 16'h0000;
    if (reg_rd) begin
      if (hit(reg_bank, reg_addr, 2'h0, `PQI_OFS_TXCTL)) s_nxt.rdata = s_r.txctl;
      else if (hit(reg_bank, reg_addr, 2'h0, `PQI_OFS_TXSTAT))
        s_nxt.rdata = {15'h0000, s_r.tx_last_ok};
      else if (hit(reg_bank, reg_addr, 2'h0, `PQI_OFS_RXCTL))
        s_nxt.rdata = {14'h0000, s_r.rxctl};
      else if (hit(reg_bank, reg_addr, 2'h2, `PQI_OFS_PNUM))
        s_nxt.rdata = {8'h00, s_r.pnum};
      else if (hit(reg_bank, reg_addr, 2'h2, `PQI_OFS_QPORTS))
        s_nxt.rdata = {rxq_empty, 1'b0, rxq_r[s_r.rxq_rp], dq_empty, 1'b0,
                       6'(dq_r[s_r.dq_rp] & `PQI_PKT_MASK)};
      else if (hit(reg_bank, reg_addr, 2'h2, `PQI_OFS_IRQ))
        s_nxt.rdata = {s_r.mask, flags};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_r <= '0;
      s_r.rx_st <= PQI_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Queue storage kept outside the state struct so it needs no reset
  always_ff @(posedge sys_clk) begin
    if (!srst) begin
      if (rx_push) rxq_r[wr_ptr(s_r.rxq_rp, s_r.rxq_cnt)] <= s_r.rx_pkt;
      if (dq_push) dq_r[wr_ptr(s_r.dq_rp, s_r.dq_cnt)] <= tx_fin_pkt;
      if (tq_push) tq_r[wr_ptr(s_r.tq_rp, s_r.tq_cnt)] <= s_r.pnum[5:0];
    end
  end

  assign reg_rdata = s_r.rdata;
  assign mem_we    = s_r.mem_we;
  assign mem_pkt   = s_r.mem_pkt;
  assign mem_addr  = s_r.mem_addr;
  assign mem_wdata = s_r.mem_wdata;
  assign alloc_req = s_r.alloc_req;
  assign free_req  = s_r.free_req;
  assign free_pkt  = s_r.free_pkt;
  assign tx_go     = s_r.tx_go;
  assign tx_pkt    = tx_fin_pkt;
  assign irq       = |(flags & s_r.mask);

  ////////////////////////////////////////////////////////////////////////////
  sequence rx_end_s;
    s_r.rx_st == PQI_RECV && !rx_overrun && rx_end;
  endsequence
  sequence rx_hdr_s;
    mem_we && mem_addr == 11'h000 ##1 mem_we && mem_addr == 11'h002;
  endsequence
  rx_hdr_order_a: assert property (@(posedge sys_clk) disable iff (srst)
    rx_end_s |=> rx_hdr_s) else $error("header words not written in order");
  rx_gate_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_r.rx_st == PQI_IDLE && !s_r.rxctl[0] |=> s_r.rx_st == PQI_IDLE)
    else $error("frame accepted while disabled");
  overrun_free_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_r.rx_st == PQI_RECV && rx_overrun |=> free_req && s_r.rx_st == PQI_IDLE)
    else $error("overrun did not free");
  bad_crc_a: assert property (@(posedge sys_clk) disable iff (srst)
    s_r.rx_st == PQI_CNT && !s_r.rx_ok && !rx_pop |=> free_req && $stable(s_r.rxq_cnt))
    else $error("bad frame queued");
  rx_flag_a: assert property (@(posedge sys_clk) disable iff (srst)
    rx_push || (flags[0] && !rx_pop) |=> flags[0]) else $error("receive flag wrong");
  rx_pop_a: assert property (@(posedge sys_clk) disable iff (srst)
    rx_pop && !rx_push |=> free_req && s_r.rxq_cnt == $past(s_r.rxq_cnt) - 1)
    else $error("receive pop failed");
  auto_rel_a: assert property (@(posedge sys_clk) disable iff (srst)
    tx_fin && tx_ok && s_r.txctl[1] && !dq_pop |=> $stable(s_r.dq_cnt) && free_req)
    else $error("auto release wrong");
  fail_stop_a: assert property (@(posedge sys_clk) disable iff (srst)
    tx_fin && !tx_ok && !(reg_wr && reg_bank == 2'h0 && reg_addr == 4'h0)
    |=> !s_r.txctl[0] && !s_r.tx_last_ok) else $error("failure did not stop");
  irq_gate_a: assert property (@(posedge sys_clk) disable iff (srst)
    irq == ((s_r.rxq_cnt != 0 && s_r.mask[0]) || (s_r.dq_cnt != 0 && s_r.mask[1])
            || (s_r.tq_cnt == 0 && s_r.mask[2]))) else $error("interrupt output wrong");

  fail_queue_a: assert property (@(posedge sys_clk) disable iff (srst)
    tx_fin && !tx_ok && !dq_pop && s_r.dq_cnt != DEPTH[AW:0]
    |=> s_r.dq_cnt == $past(s_r.dq_cnt) + 1'b1) else $error("failed packet not queued");
  tx_enqueue_a: assert property (@(posedge sys_clk) disable iff (srst)
    tq_push && !tq_pop |=> s_r.tq_cnt == $past(s_r.tq_cnt) + 1'b1)
    else $error("enqueue lost");
  ack_pop_a: assert property (@(posedge sys_clk) disable iff (srst)
    dq_pop && !dq_push |=> s_r.dq_cnt == $past(s_r.dq_cnt) - 1'b1)
    else $error("acknowledge did not pop");
  tx_drained_a: assert property (@(posedge sys_clk) disable iff (srst)
    tq_pop && s_r.tq_cnt == 1 && !tq_push |=> flags[2])
    else $error("drained flag not raised");
endmodule

// ===== src/pqi_pkg.sv
package pqi_pkg;
  typedef enum logic [3:0] {
    PQI_IDLE = 4'h1,
    PQI_RECV = 4'h2,
    PQI_STAT = 4'h4,
    PQI_CNT  = 4'h8
  } pqi_rx_st_t;
  typedef struct packed {
    logic        valid;
    logic [5:0]  pkt;
    logic        ok;
  } pqi_txdone_t;
endpackage

// ===== src/pqi_regs.svh
`ifndef PQI_REGS_SVH
`define PQI_REGS_SVH
`define PQI_OFS_TXCTL      4'h0
`define PQI_OFS_ALLOC      4'h0
`define PQI_OFS_TXSTAT     4'h2
`define PQI_OFS_PNUM       4'h2
`define PQI_OFS_QPORTS     4'h4
`define PQI_OFS_RXCTL      4'h6
`define PQI_OFS_IRQ        4'hC
`define PQI_CMD_RELEASE    16'h00A0
`define PQI_CMD_ENQUEUE    16'h00C0
`define PQI_CMD_RXPOP      16'h0080
`define PQI_ACK_TX         8'h02
`define PQI_BIT_TRANSMIT_ENABLE_BIT      0
`define PQI_BIT_RECEIVE_ENABLE_BIT       0
`define PQI_BIT_AUTOREL    1
`define PQI_IRQ_RX         0
`define PQI_IRQ_TX         1
`define PQI_IRQ_TX_QUEUE_DRAINED    2
`define PQI_PKT_MASK       16'h003F
`endif

// ===== testbench/packet_queue_interrupt_logic_test.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module packet_queue_interrupt_logic_test;
  logic        sys_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, irq;
  logic [1:0]  reg_bank = 0, reg_be = 0;
  logic [3:0]  reg_addr = 0;
  logic [15:0] reg_wdata = 0, reg_rdata, rv, rx_word = 0, rx_status = 0, mem_wdata;
  logic        rx_start = 0, rx_word_vld = 0, rx_page_need = 0, rx_overrun = 0;
  logic        rx_end = 0, rx_crc_ok = 0, tx_fail = 0, mem_we, alloc_req, free_req;
  logic        alloc_ok, tx_go, tx_done, tx_ok;
  logic [10:0] rx_bytes = 0, mem_addr;
  logic [5:0]  mem_pkt, free_pkt, alloc_pkt, tx_pkt, pe;
  int          n_fail = 0, check_count = 0, cyc = 0;
  always #10 sys_clk = ~sys_clk;
  pqi_core dut (.sys_clk(sys_clk), .srst(srst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_bank(reg_bank), .reg_addr(reg_addr), .reg_be(reg_be), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .rx_start(rx_start), .rx_word_vld(rx_word_vld), .rx_word(rx_word),
    .rx_page_need(rx_page_need), .rx_overrun(rx_overrun), .rx_end(rx_end),
    .rx_crc_ok(rx_crc_ok), .rx_status(rx_status), .rx_bytes(rx_bytes), .mem_we(mem_we),
    .mem_pkt(mem_pkt), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .alloc_req(alloc_req),
    .free_req(free_req), .free_pkt(free_pkt), .alloc_ok(alloc_ok), .alloc_pkt(alloc_pkt),
    .tx_go(tx_go), .tx_pkt(tx_pkt), .tx_done(tx_done), .tx_ok(tx_ok), .irq(irq));
  pqi_far_model p (.sys_clk(sys_clk), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .alloc_req(alloc_req), .free_req(free_req), .free_pkt(free_pkt),
    .tx_go(tx_go), .tx_pkt(tx_pkt), .tx_fail(tx_fail), .alloc_ok(alloc_ok),
    .alloc_pkt(alloc_pkt), .tx_done(tx_done), .tx_ok(tx_ok));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [1:0] b, input logic [3:0] a, input logic [1:0] be,
                    input logic [15:0] d);
    @(posedge sys_clk);
    #1;
    {reg_wr, reg_bank, reg_addr, reg_be, reg_wdata} = {1'b1, b, a, be, d};
    @(posedge sys_clk);
    #1;
    reg_wr = 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [1:0] b, input logic [3:0] a);
    @(posedge sys_clk);
    #1;
    {reg_rd, reg_bank, reg_addr, reg_be} = {1'b1, b, a, 2'b11};
    @(posedge sys_clk);
    #1;
    reg_rd = 1'b0;
    rv = reg_rdata;
  endtask
  task automatic txwait();
    for (int i = 0; i < 40 && tx_done !== 1'b1; i++) @(posedge sys_clk);
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic frame(input logic crc, input logic ovr, input logic pg);
    @(posedge sys_clk);
    #1;
    rx_start = 1'b1;
    @(posedge sys_clk);
    #1;
    rx_start = 1'b0;
    repeat (3) @(posedge sys_clk);
    for (int i = 0; i < 2; i++) begin
      @(posedge sys_clk);
      #1;
      rx_word_vld = 1'b1;
      rx_word = 16'hC0DE + 16'(i);
    end
    @(posedge sys_clk);
    #1;
    {rx_word_vld, rx_word, rx_page_need} = {1'b0, ~rx_word, pg};
    @(posedge sys_clk);
    #1;
    rx_page_need = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    {rx_overrun, rx_end} = {ovr, !ovr};
    {rx_crc_ok, rx_status, rx_bytes} = {crc, 16'h1234, 11'h03C};
    @(posedge sys_clk);
    #1;
    {rx_overrun, rx_end} = 2'b00;
    // Byte count must outlive the end strobe by one cycle
    @(posedge sys_clk);
    #1;
    {rx_crc_ok, rx_status, rx_bytes} = {!crc, 16'hEDCB, 11'h7C3};
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic give_verdict();
    if (n_fail == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge sys_clk);
    #1;
    srst = 1'b0;
    `CHK("irq", 1'b0, irq)
    rd(2'h2, 4'hC);
    `CHK("flags", 3'b100, rv[2:0])
    frame(1'b1, 1'b0, 1'b0);
    `CHK("n_alloc", 0, p.n_alloc)
    wr(2'h0, 4'h6, 2'b11, 16'h0001);
    wr(2'h2, 4'hC, 2'b10, 16'h0100);
    pe = 6'h10 + 6'(p.n_free);
    frame(1'b1, 1'b0, 1'b1);
    `CHK("n_alloc", 2, p.n_alloc)
    `CHK("word4", 16'hC0DE, p.mem[2])
    `CHK("word6", 16'hC0DF, p.mem[3])
    `CHK("status", 16'h1234, p.mem[0])
    `CHK("count", 16'h003C, p.mem[1])
    rd(2'h2, 4'h4);
    `CHK("rxhead", {1'b0, pe}, {rv[15], rv[13:8]})
    `CHK("irq", 1'b1, irq)
    wr(2'h2, 4'h0, 2'b11, 16'h0080);
    rd(2'h2, 4'h4);
    `CHK("freed", pe, p.last_free)
    `CHK("rxempty", 1'b1, rv[15])
    `CHK("irq", 1'b0, irq)
    for (int k = 0; k < 2; k++) begin
      pe = 6'h10 + 6'(p.n_free);
      frame(1'b0, k == 1, 1'b0);
      rd(2'h2, 4'h4);
      `CHK("freed", pe, p.last_free)
      `CHK("rxempty", 1'b1, rv[15])
      `CHK("irq", 1'b0, irq)
    end
    wr(2'h0, 4'h0, 2'b11, 16'h0000);
    for (int k = 0; k < 2; k++) begin
      wr(2'h2, 4'h2, 2'b01, 16'h0005 + 16'(k));
      wr(2'h2, 4'h0, 2'b11, 16'h00C0);
    end
    rd(2'h2, 4'hC);
    `CHK("tx_queue_drained", 1'b0, rv[2])
    wr(2'h2, 4'hC, 2'b10, 16'h0700);
    wr(2'h0, 4'h0, 2'b11, 16'h0001);
    txwait();
    txwait();
    rd(2'h2, 4'hC);
    `CHK("flags", 3'b110, rv[2:0])
    `CHK("irq", 1'b1, irq)
    rd(2'h0, 4'h2);
    `CHK("txok", 1'b1, rv[0])
    for (int k = 0; k < 2; k++) begin
      rd(2'h2, 4'h4);
      `CHK("txhead", {1'b0, 6'(5 + k)}, {rv[7], rv[5:0]})
      wr(2'h2, 4'hC, 2'b01, 16'h0002);
    end
    rd(2'h2, 4'h4);
    `CHK("cmplempty", 1'b1, rv[7])
    wr(2'h2, 4'h0, 2'b11, 16'h00A0);
    rd(2'h2, 4'h2);
    `CHK("freed", 6'h06, p.last_free)
    `CHK("pnum", 8'h06, rv[7:0])
    wr(2'h0, 4'h0, 2'b11, 16'h0003);
    wr(2'h2, 4'h2, 2'b01, 16'h0008);
    wr(2'h2, 4'h0, 2'b11, 16'h00C0);
    txwait();
    rd(2'h2, 4'h4);
    `CHK("freed", 6'h08, p.last_free)
    `CHK("cmplempty", 1'b1, rv[7])
    tx_fail = 1'b1;
    wr(2'h2, 4'h2, 2'b01, 16'h0009);
    wr(2'h2, 4'h0, 2'b11, 16'h00C0);
    txwait();
    rd(2'h2, 4'h4);
    `CHK("txhead", {1'b0, 6'h09}, {rv[7], rv[5:0]})
    rd(2'h0, 4'h0);
    `CHK("transmit_enable_bit", 1'b0, rv[0])
    rd(2'h0, 4'h2);
    `CHK("txok", 1'b0, rv[0])
    rd(2'h2, 4'hC);
    `CHK("txflag", 1'b1, rv[1])
    rd(2'h2, 4'h2);
    pe = rv[5:0];
    wr(2'h2, 4'h2, 2'b01, 16'hFF0B);
    wr(2'h2, 4'h2, 2'b01, {10'h000, pe});
    rd(2'h2, 4'h2);
    `CHK("pnum", 16'h0009, rv)
    tx_fail = 1'b0;
    wr(2'h2, 4'hC, 2'b01, 16'h0002);
    wr(2'h0, 4'h0, 2'b11, 16'h0003);
    rd(2'h0, 4'h0);
    `CHK("transmit_enable_bit", 1'b1, rv[0])
    give_verdict();
  end
endmodule

// ===== testbench/pqi_far_model.sv
`timescale 1ns/1ps
module pqi_far_model (
  input  wire logic        sys_clk,
  input  wire logic        mem_we,
  input  wire logic [10:0] mem_addr,
  input  wire logic [15:0] mem_wdata,
  input  wire logic        alloc_req,
  input  wire logic        free_req,
  input  wire logic [5:0]  free_pkt,
  input  wire logic        tx_go,
  input  wire logic [5:0]  tx_pkt,
  input  wire logic        tx_fail,
  output logic             alloc_ok,
  output logic      [5:0]  alloc_pkt,
  output logic             tx_done,
  output logic             tx_ok
);
  logic [15:0] mem [0:7];
  int          n_alloc = 0;
  int          n_free = 0;
  logic [5:0]  last_free = 6'h3F;
  logic [5:0]  last_tx = 6'h3F;
  initial begin
    alloc_ok = 1'b0;
    alloc_pkt = 6'h2A;
    tx_done = 1'b0;
    tx_ok = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Number moves on only after a release, so pages of one frame share it
  always @(posedge sys_clk) begin
    if (alloc_req) begin
      #1;
      alloc_ok = 1'b1;
      alloc_pkt = 6'h10 + 6'(n_free);
      n_alloc++;
      @(posedge sys_clk);
      #1;
      alloc_ok = 1'b0;
      alloc_pkt = ~alloc_pkt;
    end
  end
  // Only the first sixteen bytes of a packet are kept
  always @(posedge sys_clk) begin
    if (free_req) begin
      n_free++;
      last_free = free_pkt;
    end
    if (mem_we && mem_addr < 11'h010) begin
      mem[mem_addr[3:1]] = mem_wdata;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Slow sender; result line flips when not qualified so a stale value is not read
  always @(posedge sys_clk) begin
    if (tx_go) begin
      last_tx = tx_pkt;
      repeat (3) @(posedge sys_clk);
      #1;
      tx_done = 1'b1;
      tx_ok = !tx_fail;
      @(posedge sys_clk);
      #1;
      tx_done = 1'b0;
      tx_ok = tx_fail;
    end
  end
endmodule
